// ### verilog/isvu_top.sv
`timescale 1ns/100ps
module isvu_top
   import isvu_pkg::*;
(
   input  wire logic        i_sys_clk,
   input  wire logic        i_nrst,
   input  wire logic        i_psel,
   input  wire logic        i_penable,
   input  wire logic        i_pwrite,
   input  wire logic [11:0] i_paddr,
   input  wire logic [31:0] i_pwdata,
   output logic      [31:0] o_prdata,
   output logic             o_pready,
   output logic             o_pslverr,
   input  wire logic        i_nmi_n,
   input  wire logic        i_wdt_evt,
   input  wire logic        i_osc_evt,
   input  wire logic        i_lvd_evt,
   input  wire logic        i_ss_evt,
   input  wire logic        i_dbc_evt,
   input  wire logic        i_exec_und,
   input  wire logic        i_exec_into,
   input  wire logic        i_exec_brk,
   input  wire logic        i_exec_int,
   input  wire logic [5:0]  i_exec_int_num,
   input  wire logic        i_alu_valid,
   input  wire logic [3:0]  i_alu_op,
   input  wire logic        i_alu_ovf,
   input  wire logic        i_fetch_valid,
   input  wire logic [19:0] i_fetch_addr,
   input  wire logic [31:0] i_peri_req,
   input  wire logic        i_flag_i,
   input  wire logic        i_reti,
   input  wire logic        i_reti_u,
   input  wire logic        i_int_ack,
   input  wire logic        i_vec_ack,
   input  wire logic [31:0] i_vec_data,
   output logic             o_int_req,
   output logic      [19:0] o_int_handler,
   output logic      [5:0]  o_int_num,
   output logic      [3:0]  o_int_src,
   output logic             o_vec_req,
   output logic      [19:0] o_vec_addr,
   output logic             o_u_write,
   output logic             o_u_next,
   output logic             o_push_u,
   output logic             o_ovf_flag,
   output logic             o_id_match
);

   isvu_state_s r;
   isvu_state_s next_r;

   function automatic logic ovf_op(input logic [3:0] op);
      ovf_op = (op != ISVU_ALU_OTHER) && (op <= ISVU_ALU_SUB);
   endfunction : ovf_op

   function automatic logic [19:0] fvec_addr(input int idx);
      fvec_addr = ISVU_FVEC_FIRST + 20'(idx * ISVU_VEC_BYTES);
   endfunction : fvec_addr

   function automatic logic [19:0] reloc_addr(input logic [19:0] b,
                                              input logic [5:0]  n);
      reloc_addr = b + {12'h000, n, 2'b00};
   endfunction : reloc_addr

   logic [11:0] fidx_ofs;
   logic [3:0]  fidx;
   logic        apb_set;
   logic        apb_wr;
   logic        fvec_hit;
   logic [31:0] peri_live;
   logic [ISVU_PB_NUM-1:0] pend_set;
   logic        pick_any;
   int          pick;
   logic        peri_any;
   logic [5:0]  peri_num;
   logic        reloc;
   logic [5:0]  sel_num;
   isvu_src_e   sel_src;
   int          sel_fv;

   always_comb begin
      fidx_ofs = i_paddr - ISVU_OFS_FVEC;
      fidx     = fidx_ofs[5:2];
      fvec_hit = (i_paddr >= ISVU_OFS_FVEC) && (i_paddr <= ISVU_OFS_FVEC_END);
      apb_set  = i_psel && !i_penable;
      apb_wr   = i_psel && i_penable && r.pready && i_pwrite;
      // peripheral requests gated by global enable and per-source enable bit
      peri_live = i_flag_i ? (i_peri_req & r.peri_en) : 32'h0000_0000;
      peri_live[0] = 1'b0;
      peri_any = 1'b0;
      peri_num = 6'h00;
      for (int k = 31; k >= 1; k--) begin
         if (peri_live[k]) begin
            peri_any = 1'b1;
            peri_num = 6'(k);
         end
      end
      pend_set = '0;
      pend_set[ISVU_PB_NMI] = r.nmi_prev && !r.nmi_s2;
      pend_set[ISVU_PB_WDT] = i_wdt_evt;
      pend_set[ISVU_PB_OSC] = i_osc_evt;
      pend_set[ISVU_PB_LVD] = i_lvd_evt;
      pend_set[ISVU_PB_SS]  = i_ss_evt;
      pend_set[ISVU_PB_DBC] = i_dbc_evt;
      pend_set[ISVU_PB_AM]  = i_fetch_valid &&
         ((r.match_en[0] && i_fetch_addr == r.match0) ||
          (r.match_en[1] && i_fetch_addr == r.match1));
      pend_set[ISVU_PB_UND] = i_exec_und;
      pend_set[ISVU_PB_OVF] = i_exec_into && r.ovf;
      pend_set[ISVU_PB_BRK] = i_exec_brk;
      pend_set[ISVU_PB_INT] = i_exec_int;
      pick_any = 1'b0;
      pick     = 0;
      for (int k = ISVU_PB_NUM - 1; k >= 0; k--) begin
         if (r.pend[k]) begin
            pick_any = 1'b1;
            pick     = k;
         end
      end
      reloc   = 1'b0;
      sel_num = ISVU_NUM_BRK;
      sel_fv  = ISVU_FV_RST;
      sel_src = ISVU_SRC_NONE;
      if (pick_any) begin
         unique case (pick)
            ISVU_PB_DBC: begin
               sel_src = ISVU_SRC_DBC;
               sel_fv  = ISVU_FV_DBC;
            end
            ISVU_PB_NMI: begin
               sel_src = ISVU_SRC_NMI;
               sel_fv  = ISVU_FV_NMI;
            end
            ISVU_PB_WDT: begin
               sel_src = ISVU_SRC_WDT;
               sel_fv  = ISVU_FV_WDT;
            end
            ISVU_PB_OSC: begin
               sel_src = ISVU_SRC_OSC;
               sel_fv  = ISVU_FV_WDT;
            end
            ISVU_PB_LVD: begin
               sel_src = ISVU_SRC_LVD;
               sel_fv  = ISVU_FV_WDT;
            end
            ISVU_PB_SS: begin
               sel_src = ISVU_SRC_SS;
               sel_fv  = ISVU_FV_SS;
            end
            ISVU_PB_AM: begin
               sel_src = ISVU_SRC_AM;
               sel_fv  = ISVU_FV_AM;
            end
            ISVU_PB_UND: begin
               sel_src = ISVU_SRC_UND;
               sel_fv  = ISVU_FV_UND;
            end
            ISVU_PB_OVF: begin
               sel_src = ISVU_SRC_OVF;
               sel_fv  = ISVU_FV_OVF;
            end
            ISVU_PB_BRK: begin
               sel_src = ISVU_SRC_BRK;
               sel_fv  = ISVU_FV_BRK;
               // top byte of the break entry selects the relocatable table
               reloc   = r.fvec[ISVU_FV_BRK][31:24] == ISVU_BRK_RELOC;
            end
            default: begin
               sel_src = ISVU_SRC_INT;
               sel_num = r.int_num;
               reloc   = 1'b1;
            end
         endcase
      end else if (peri_any) begin
         sel_src = ISVU_SRC_PERI;
         sel_num = peri_num;
         reloc   = 1'b1;
      end
   end

   always_comb begin
      next_r = r;
      next_r.nmi_s1   = i_nmi_n;
      next_r.nmi_s2   = r.nmi_s1;
      next_r.nmi_prev = r.nmi_s2;
      if (i_alu_valid && ovf_op(i_alu_op)) begin
         next_r.ovf = i_alu_ovf;
      end
      if (i_exec_int) begin
         next_r.int_num = i_exec_int_num;
      end
      next_r.u_write = 1'b0;
      next_r.push_u  = 1'b0;
      next_r.rd_req  = 1'b0;
      if (i_reti) begin
         next_r.u_write = 1'b1;
         next_r.u_next  = i_reti_u;
      end
      unique case (r.state)
         ISVU_IDLE: begin
            if (pick_any || peri_any) begin
               next_r.src = sel_src;
               next_r.num = sel_num;
               // special sources carry no mask at all
               if (pick_any) begin
                  next_r.pend[pick] = 1'b0;
               end
               if (reloc && sel_num < ISVU_NUM_USER_MIN) begin
                  next_r.push_u  = 1'b1;
                  next_r.u_write = 1'b1;
                  next_r.u_next  = 1'b0;
               end
               // numbers 32 to 63 keep the selected stack pointer
               if (reloc) begin
                  next_r.rd_req  = 1'b1;
                  next_r.rd_addr = reloc_addr(r.base, sel_num);
                  next_r.state   = ISVU_FETCH;
               end else begin
                  next_r.handler = r.fvec[sel_fv][19:0];
                  next_r.req     = 1'b1;
                  next_r.state   = ISVU_PRESENT;
               end
            end
         end
         ISVU_FETCH: begin
            if (i_vec_ack) begin
               next_r.handler = i_vec_data[19:0];
               next_r.req     = 1'b1;
               next_r.state   = ISVU_PRESENT;
            end else begin
               next_r.rd_req = 1'b1;
            end
         end
         ISVU_PRESENT: begin
            if (i_int_ack) begin
               next_r.req   = 1'b0;
               next_r.state = ISVU_IDLE;
            end
         end
         default: next_r.state = ISVU_IDLE;
      endcase
      // a new event in the clearing cycle still sets its bit
      next_r.pend = next_r.pend | pend_set;
      next_r.id_match = {r.fvec[ISVU_FV_RST][31:24],
                         r.fvec[ISVU_FV_NMI][31:24],
                         r.fvec[ISVU_FV_WDT][31:24]} == r.id_hi &&
                        {r.fvec[ISVU_FV_SS][31:24],
                         r.fvec[ISVU_FV_AM][31:24],
                         r.fvec[ISVU_FV_OVF][31:24],
                         r.fvec[ISVU_FV_UND][31:24]} == r.id_lo;
      next_r.pslverr = 1'b0;
      next_r.pready = apb_set;
      if (apb_set) begin
         next_r.pslverr = 1'b0;
         next_r.prdata  = 32'h0000_0000;
         if (fvec_hit) begin
            next_r.prdata = r.fvec[fidx];
         end else begin
            unique case (i_paddr)
               ISVU_OFS_MATCH0:  next_r.prdata = {12'h000, r.match0};
               ISVU_OFS_MATCH1:  next_r.prdata = {12'h000, r.match1};
               ISVU_OFS_MATCHEN: next_r.prdata = {30'h0, r.match_en};
               ISVU_OFS_BASE:    next_r.prdata = {12'h000, r.base};
               ISVU_OFS_PERIEN:  next_r.prdata = r.peri_en;
               ISVU_OFS_ID_LO:   next_r.prdata = r.id_lo;
               ISVU_OFS_ID_HI:   next_r.prdata = {8'h00, r.id_hi};
               ISVU_OFS_STATUS: begin
                  next_r.prdata[ISVU_ST_OVF]  = r.ovf;
                  next_r.prdata[ISVU_ST_IDOK] = r.id_match;
                  next_r.prdata[ISVU_ST_BUSY] = r.state != ISVU_IDLE;
                  next_r.prdata[ISVU_ST_REQ]  = r.req;
               end
               default: next_r.pslverr = 1'b1;
            endcase
         end
      end
      if (apb_wr && !r.pslverr) begin
         if (fvec_hit) begin
            next_r.fvec[fidx] = i_pwdata;
         end else begin
            unique case (i_paddr)
               ISVU_OFS_MATCH0:  next_r.match0   = i_pwdata[19:0];
               ISVU_OFS_MATCH1:  next_r.match1   = i_pwdata[19:0];
               ISVU_OFS_MATCHEN: next_r.match_en = i_pwdata[1:0];
               ISVU_OFS_BASE:    next_r.base     = i_pwdata[19:0];
               ISVU_OFS_PERIEN:  next_r.peri_en  = i_pwdata;
               ISVU_OFS_ID_LO:   next_r.id_lo    = i_pwdata;
               ISVU_OFS_ID_HI:   next_r.id_hi    = i_pwdata[23:0];
               default: ;
            endcase
         end
      end
   end

   always_ff @(posedge i_sys_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         r          <= '0;
         r.nmi_s1   <= 1'b1;
         r.nmi_s2   <= 1'b1;
         r.nmi_prev <= 1'b1;
         r.state    <= ISVU_IDLE;
         r.src      <= ISVU_SRC_NONE;
      end else begin
         r <= next_r;
      end
   end

   assign o_prdata      = r.prdata;
   assign o_pready      = r.pready;
   assign o_pslverr     = r.pslverr;
   assign o_int_req     = r.req;
   assign o_int_handler = r.handler;
   assign o_int_num     = r.num;
   assign o_int_src     = r.src;
   assign o_vec_req     = r.rd_req;
   assign o_vec_addr    = r.rd_addr;
   assign o_u_write     = r.u_write;
   assign o_u_next      = r.u_next;
   assign o_push_u      = r.push_u;
   assign o_ovf_flag    = r.ovf;
   assign o_id_match    = r.id_match;

endmodule : isvu_top

// ### verilog/isvu_pkg.sv
package isvu_pkg;

   // register byte offsets on the apb port
   localparam logic [11:0] ISVU_OFS_MATCH0  = 12'h000;
   localparam logic [11:0] ISVU_OFS_MATCH1  = 12'h004;
   localparam logic [11:0] ISVU_OFS_MATCHEN = 12'h008;
   localparam logic [11:0] ISVU_OFS_BASE    = 12'h00c;
   localparam logic [11:0] ISVU_OFS_PERIEN  = 12'h010;
   localparam logic [11:0] ISVU_OFS_STATUS  = 12'h014;
   localparam logic [11:0] ISVU_OFS_ID_LO   = 12'h018;
   localparam logic [11:0] ISVU_OFS_ID_HI   = 12'h01c;
   localparam logic [11:0] ISVU_OFS_FVEC    = 12'h040;
   localparam logic [11:0] ISVU_OFS_FVEC_END = 12'h060;

   // status register bit positions
   localparam int ISVU_ST_OVF   = 0;
   localparam int ISVU_ST_IDOK  = 1;
   localparam int ISVU_ST_BUSY  = 2;
   localparam int ISVU_ST_REQ   = 3;

   // fixed vector table at the top of the address space
   localparam logic [19:0] ISVU_FVEC_FIRST = 20'hfffdc;
   localparam logic [19:0] ISVU_FVEC_LAST  = 20'hfffff;
   localparam int          ISVU_VEC_BYTES  = 4;
   localparam int          ISVU_FVEC_NUM   = 9;
   localparam logic [7:0]  ISVU_BRK_RELOC  = 8'hff;
   localparam int          ISVU_RELOC_SPAN = 256;

   // fixed vector slots, in address order
   localparam int ISVU_FV_UND = 0;
   localparam int ISVU_FV_OVF = 1;
   localparam int ISVU_FV_BRK = 2;
   localparam int ISVU_FV_AM  = 3;
   localparam int ISVU_FV_SS  = 4;
   localparam int ISVU_FV_WDT = 5;
   localparam int ISVU_FV_DBC = 6;
   localparam int ISVU_FV_NMI = 7;
   localparam int ISVU_FV_RST = 8;

   // software interrupt number ranges
   localparam logic [5:0] ISVU_NUM_BRK      = 6'h00;
   localparam logic [5:0] ISVU_NUM_USER_MIN = 6'h20;

   // pending bits, lower index taken first
   localparam int ISVU_PB_DBC = 0;
   localparam int ISVU_PB_NMI = 1;
   localparam int ISVU_PB_WDT = 2;
   localparam int ISVU_PB_OSC = 3;
   localparam int ISVU_PB_LVD = 4;
   localparam int ISVU_PB_SS  = 5;
   localparam int ISVU_PB_AM  = 6;
   localparam int ISVU_PB_UND = 7;
   localparam int ISVU_PB_OVF = 8;
   localparam int ISVU_PB_BRK = 9;
   localparam int ISVU_PB_INT = 10;
   localparam int ISVU_PB_NUM = 11;

   // alu operation codes; all but ISVU_ALU_OTHER update the overflow flag
   typedef enum logic [3:0] {
      ISVU_ALU_OTHER, ISVU_ALU_ABS, ISVU_ALU_ADC, ISVU_ALU_ADCF,
      ISVU_ALU_ADD, ISVU_ALU_CMP, ISVU_ALU_DIV, ISVU_ALU_DIVU,
      ISVU_ALU_DIVX, ISVU_ALU_NEG, ISVU_ALU_RMPA, ISVU_ALU_SBB,
      ISVU_ALU_SHA, ISVU_ALU_SUB
   } isvu_alu_e;

   typedef enum logic [3:0] {
      ISVU_SRC_NONE, ISVU_SRC_UND, ISVU_SRC_OVF, ISVU_SRC_BRK,
      ISVU_SRC_INT, ISVU_SRC_AM, ISVU_SRC_SS, ISVU_SRC_WDT,
      ISVU_SRC_OSC, ISVU_SRC_LVD, ISVU_SRC_DBC, ISVU_SRC_NMI,
      ISVU_SRC_PERI
   } isvu_src_e;

   typedef enum logic [1:0] {
      ISVU_IDLE, ISVU_FETCH, ISVU_PRESENT
   } isvu_state_e;

   typedef struct packed {
      logic                   nmi_s1;
      logic                   nmi_s2;
      logic                   nmi_prev;
      logic [ISVU_PB_NUM-1:0] pend;
      logic [5:0]             int_num;
      logic                   ovf;
      logic [19:0]            match0;
      logic [19:0]            match1;
      logic [1:0]             match_en;
      logic [19:0]            base;
      logic [31:0]            peri_en;
      logic [8:0][31:0]       fvec;
      logic [31:0]            id_lo;
      logic [23:0]            id_hi;
      logic                   id_match;
      logic [31:0]            prdata;
      logic                   pready;
      logic                   pslverr;
      isvu_state_e            state;
      logic                   req;
      logic [19:0]            handler;
      logic [5:0]             num;
      isvu_src_e              src;
      logic                   rd_req;
      logic [19:0]            rd_addr;
      logic                   u_write;
      logic                   u_next;
      logic                   push_u;
   } isvu_state_s;

endpackage : isvu_pkg

// ### tb/isvu_asserts.sv
`timescale 1ns/100ps
module isvu_asserts
   import isvu_pkg::*;
(
   input wire logic        i_sys_clk,
   input wire logic        i_nrst,
   input wire logic        i_psel,
   input wire logic        i_penable,
   input wire logic        o_pready,
   input wire logic        i_alu_valid,
   input wire logic [3:0]  i_alu_op,
   input wire logic        i_alu_ovf,
   input wire logic        o_ovf_flag,
   input wire logic        i_vec_ack,
   input wire logic [31:0] i_vec_data,
   input wire logic        i_int_ack,
   input wire logic        i_flag_i,
   input wire logic        i_reti,
   input wire logic        i_reti_u,
   input wire logic        o_int_req,
   input wire logic [19:0] o_int_handler,
   input wire logic [3:0]  o_int_src,
   input wire logic        o_vec_req,
   input wire logic [19:0] o_vec_addr,
   input wire logic        o_u_write,
   input wire logic        o_u_next,
   input wire logic        o_push_u
);
   default clocking @(posedge i_sys_clk); endclocking
   default disable iff (!i_nrst);
   logic [19:0] vd_q;
   // last entry word answered by memory
   always_ff @(posedge i_sys_clk or negedge i_nrst) begin
      if (!i_nrst) vd_q <= 20'h0;
      else if (i_vec_ack) vd_q <= i_vec_data[19:0];
   end
   sequence vec_wait; o_vec_req && !i_vec_ack; endsequence
   sequence irq_wait; o_int_req && !i_int_ack; endsequence
   apb_ready_a: assert property (
      i_psel && !i_penable |=> o_pready ##1 !o_pready)
      else $error("pready not one cycle after setup");
   ovf_update_a: assert property (i_alu_valid |=> o_ovf_flag ==
      ($past(i_alu_op) == 4'h0 || $past(i_alu_op) > 4'hd ?
       $past(o_ovf_flag) : $past(i_alu_ovf)))
      else $error("overflow flag not updated by alu");
   vec_hold_a: assert property (vec_wait |=> o_vec_req && $stable(o_vec_addr))
      else $error("vector fetch dropped early");
   irq_hold_a: assert property (
      irq_wait |=> o_int_req && $stable(o_int_handler))
      else $error("request dropped before accept");
   irq_drop_a: assert property (o_int_req && i_int_ack |=> !o_int_req)
      else $error("request stays after accept");
   handler_load_a: assert property (
      $rose(o_int_req) && $past(i_vec_ack) |-> o_int_handler == vd_q)
      else $error("handler differs from entry low bytes");
   push_clear_a: assert property (
      o_push_u |-> o_u_write && !o_u_next ##1 !o_push_u)
      else $error("push without clearing stack select");
   reti_restore_a: assert property (
      i_reti && !o_int_req && !o_vec_req |=>
      o_u_write && (o_push_u || o_u_next == $past(i_reti_u)))
      else $error("stack select not restored on return");
   peri_gate_a: assert property (
      $rose(o_vec_req) && o_int_src == ISVU_SRC_PERI |-> $past(i_flag_i))
      else $error("peripheral taken with interrupts disabled");
endmodule : isvu_asserts
bind isvu_top isvu_asserts u_isvu_asserts (.*);

// ### tb/isvu_partner.sv
`timescale 1ns/100ps
module isvu_partner (
   input  wire logic        i_clk,
   input  wire logic        i_nrst,
   input  wire logic [3:0]  i_delay,
   input  wire logic        i_vec_req,
   input  wire logic [19:0] i_vec_addr,
   input  wire logic        i_int_req,
   output logic             o_vec_ack,
   output logic      [31:0] o_vec_data,
   output logic             o_int_ack
);
   logic [3:0] vcnt;
   logic [3:0] icnt;
   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         vcnt <= 4'h0;
         icnt <= 4'h0;
         o_vec_ack <= 1'h0;
         o_int_ack <= 1'h0;
         o_vec_data <= 32'h0;
      end else begin
         o_vec_ack <= 1'h0;
         o_int_ack <= 1'h0;
         vcnt <= 4'h0;
         icnt <= 4'h0;
         // bus released between answers: never keep the old word
         o_vec_data <= ~o_vec_data;
         if (i_vec_req && !o_vec_ack) begin
            vcnt <= vcnt + 4'h1;
            if (vcnt == i_delay) begin
               o_vec_ack <= 1'h1;
               o_vec_data <= {12'h5c3, i_vec_addr ^ 20'h0f0f0};
            end
         end
         if (i_int_req && !o_int_ack) begin
            icnt <= icnt + 4'h1;
            if (icnt == i_delay) o_int_ack <= 1'h1;
         end
      end
   end
endmodule : isvu_partner

// ### tb/isvu_top_tb.sv
`timescale 1ns/100ps
module isvu_top_tb
   import isvu_pkg::*;
;
   logic i_sys_clk = 1'h0, i_nrst = 1'h0, i_psel = 1'h0, i_penable = 1'h0;
   logic i_pwrite = 1'h0, i_nmi_n = 1'h1, i_alu_ovf = 1'h0, eovf = 1'h0;
   logic i_flag_i = 1'h0, i_reti = 1'h0, i_reti_u = 1'h0, rerr;
   logic [11:0] i_paddr = 12'h0;
   logic [31:0] i_pwdata = 32'h0, i_peri_req = 32'h0, rs = 32'h3b36;
   logic [31:0] i_vec_data, o_prdata, rdat, t;
   logic [31:0] fv [9];
   logic [19:0] i_fetch_addr = 20'h0, o_int_handler, o_vec_addr, base;
   logic [5:0]  i_exec_int_num = 6'h0, o_int_num;
   logic [5:0]  cn [4] = '{6'h00, 6'h1f, 6'h20, 6'h3f};
   logic [3:0]  i_alu_op = 4'h0, o_int_src, dly = 4'h0;
   logic [10:0] ev = 11'h0;
   logic i_vec_ack, i_int_ack, o_pready, o_pslverr, o_int_req, o_vec_req;
   logic o_u_write, o_u_next, o_push_u, o_ovf_flag, o_id_match;
   logic i_wdt_evt, i_osc_evt, i_lvd_evt, i_ss_evt, i_dbc_evt, i_exec_und;
   logic i_exec_into, i_exec_brk, i_exec_int, i_fetch_valid, i_alu_valid;
   int fail_count = 0, n_compared = 0, npush = 0, p;
   isvu_src_e srcs [6] = '{ISVU_SRC_WDT, ISVU_SRC_OSC, ISVU_SRC_LVD,
      ISVU_SRC_SS, ISVU_SRC_DBC, ISVU_SRC_UND};
   int fidx [6] = '{5, 5, 5, 4, 6, 0};
   assign {i_alu_valid, i_fetch_valid, i_exec_int, i_exec_brk, i_exec_into,
      i_exec_und, i_dbc_evt, i_ss_evt, i_lvd_evt, i_osc_evt, i_wdt_evt} = ev;
   always #2 i_sys_clk = ~i_sys_clk;
   always @(posedge i_sys_clk) if (o_push_u === 1'h1) npush++;
   isvu_top u_isvu_top (.*);
   isvu_partner u_isvu_partner (.i_clk(i_sys_clk), .i_nrst(i_nrst),
      .i_delay(dly), .i_vec_req(o_vec_req), .i_vec_addr(o_vec_addr),
      .i_int_req(o_int_req), .o_vec_ack(i_vec_ack),
      .o_vec_data(i_vec_data), .o_int_ack(i_int_ack));
   function automatic logic [31:0] rnd();
      rs = rs ^ (rs << 13);
      rs = rs ^ (rs >> 17);
      rs = rs ^ (rs << 5);
      return rs;
   endfunction : rnd
   function automatic logic [19:0] reloc(input logic [5:0] n);
      return (base + {12'h0, n, 2'h0}) ^ 20'h0f0f0;
   endfunction : reloc
   task automatic results();
      $display("compared %0d, mismatched %0d", n_compared, fail_count);
      if (fail_count == 0 && n_compared > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask : results
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         fail_count++;
         $display("unexpected at %0t: saw %h, want %h", $time, seen, exp);
      end
   endtask : chk
   task automatic hang();
      fail_count++;
      $display("unexpected at %0t: no answer", $time);
      results();
   endtask : hang
   task automatic apb(input logic w, input logic [11:0] a,
                      input logic [31:0] d);
      int n;
      @(posedge i_sys_clk);
      i_psel <= 1'h1;
      i_pwrite <= w;
      i_paddr <= a;
      i_pwdata <= d;
      @(posedge i_sys_clk);
      i_penable <= 1'h1;
      for (n = 0; n < 64 && o_pready !== 1'h1; n++) @(posedge i_sys_clk);
      if (n >= 64) hang();
      rdat = o_prdata;
      rerr = o_pslverr;
      i_psel <= 1'h0;
      i_penable <= 1'h0;
   endtask : apb
   task automatic fire(input int k);
      @(posedge i_sys_clk);
      ev <= 11'h1 << k;
      @(posedge i_sys_clk);
      ev <= 11'h0;
   endtask : fire
   task automatic alu(input logic [3:0] op, input logic v);
      @(posedge i_sys_clk);
      i_alu_op <= op;
      i_alu_ovf <= v;
      if (op != 4'h0 && op <= 4'hd) eovf = v;
      fire(10);
      @(negedge i_sys_clk);
      chk(32'(o_ovf_flag), 32'(eovf));
   endtask : alu
   task automatic quiet();
      repeat (12) @(negedge i_sys_clk);
      chk(32'({o_int_req, o_vec_req}), 32'h0);
   endtask : quiet
   task automatic wt(input logic v);
      int n;
      for (n = 0; n < 200 && o_int_req !== v; n++) @(negedge i_sys_clk);
      if (n >= 200) hang();
   endtask : wt
   task automatic irq(input logic [3:0] s, input logic [19:0] h,
                      input logic [5:0] m);
      wt(1'h1);
      chk(32'(o_int_src), 32'(s));
      chk(32'(o_int_handler), 32'(h));
      chk(32'(o_int_num), 32'(m));
      wt(1'h0);
   endtask : irq
   initial begin
      repeat (10) @(posedge i_sys_clk);
      i_nrst <= 1'h1;
      repeat (2) @(posedge i_sys_clk);
      apb(1'h0, ISVU_OFS_PERIEN, 32'h0);
      chk(rdat, 32'h0);
      apb(1'h1, 12'h030, 32'h1);
      chk(32'(rerr), 32'h1);
      t = rnd();
      base = {t[19:2], 2'h0};
      apb(1'h1, ISVU_OFS_BASE, 32'(base));
      for (int k = 0; k < 9; k++) begin
         fv[k] = rnd();
         if (k == 2) fv[k][31:24] = 8'h00;
         apb(1'h1, ISVU_OFS_FVEC + 12'(4 * k), fv[k]);
      end
      apb(1'h0, ISVU_OFS_FVEC + 12'h00c, 32'h0);
      chk(rdat, fv[3]);
      t = {fv[4][31:24], fv[3][31:24], fv[1][31:24], fv[0][31:24]};
      apb(1'h1, ISVU_OFS_ID_LO, t);
      apb(1'h1, ISVU_OFS_ID_HI, {8'h0, fv[8][31:24], fv[7][31:24],
         fv[5][31:24]});
      apb(1'h0, ISVU_OFS_STATUS, 32'h0);
      chk(32'(o_id_match), 32'h1);
      chk(32'(rdat[ISVU_ST_IDOK]), 32'h1);
      apb(1'h1, ISVU_OFS_ID_LO, ~t);
      repeat (2) @(negedge i_sys_clk);
      chk(32'(o_id_match), 32'h0);
      for (int i = 0; i < 16; i++) begin
         t = rnd();
         alu(4'(i), t[0]);
      end
      alu(ISVU_ALU_ADD, 1'h0);
      fire(6);
      quiet();
      alu(ISVU_ALU_SHA, 1'h1);
      fire(6);
      irq(ISVU_SRC_OVF, fv[1][19:0], 6'h0);
      $display("overflow test done");
      for (int k = 0; k < 6; k++) begin
         fire(k);
         irq(srcs[k], fv[fidx[k]][19:0], 6'h0);
      end
      @(posedge i_sys_clk);
      i_nmi_n <= 1'h0;
      irq(ISVU_SRC_NMI, fv[7][19:0], 6'h0);
      @(posedge i_sys_clk);
      i_nmi_n <= 1'h1;
      quiet();
      fire(7);
      irq(ISVU_SRC_BRK, fv[2][19:0], 6'h0);
      apb(1'h1, ISVU_OFS_FVEC + 12'h008, {8'hff, fv[2][23:0]});
      fire(7);
      irq(ISVU_SRC_BRK, reloc(6'h0), 6'h0);
      $display("special test done");
      for (int i = 0; i < 10; i++) begin
         t = rnd();
         @(posedge i_sys_clk);
         dly <= t[9:6];
         i_exec_int_num <= (i < 4) ? cn[i] : t[5:0];
         p = npush;
         fire(8);
         irq(ISVU_SRC_INT, reloc(i_exec_int_num), i_exec_int_num);
         chk(32'(npush - p), 32'(i_exec_int_num < 6'h20));
      end
      apb(1'h1, ISVU_OFS_PERIEN, 32'h20);
      i_peri_req <= 32'h20;
      quiet();
      @(posedge i_sys_clk);
      i_flag_i <= 1'h1;
      for (int n = 0; n < 50 && o_vec_req !== 1'h1; n++) @(posedge i_sys_clk);
      i_flag_i <= 1'h0;
      i_peri_req <= 32'h0;
      irq(ISVU_SRC_PERI, reloc(6'h05), 6'h05);
      $display("vector test done");
      for (int c = 0; c < 2; c++) begin
         t = rnd();
         apb(1'h1, ISVU_OFS_MATCH0 + 12'(4 * c), {12'h0, t[19:0]});
         apb(1'h1, ISVU_OFS_MATCHEN, 32'h0);
         i_fetch_addr <= t[19:0];
         fire(9);
         quiet();
         apb(1'h1, ISVU_OFS_MATCHEN, 32'(1 << c));
         fire(9);
         irq(ISVU_SRC_AM, fv[3][19:0], 6'h0);
      end
      @(posedge i_sys_clk);
      i_reti <= 1'h1;
      i_reti_u <= 1'h1;
      @(posedge i_sys_clk);
      i_reti <= 1'h0;
      @(negedge i_sys_clk);
      chk(32'({o_u_write, o_u_next}), 32'h3);
      $display("match and return test done");
      results();
   end
   initial begin
      #200000;
      hang();
   end
endmodule : isvu_top_tb
